// ### bvs_shifter.sv
`timescale 1ns/10ps
// Function
// - Sixteen palette entries, each twelve bits: four red, green, blue.
// - Low resolution indexes all sixteen entries; medium only four.
// - Monochrome uses only entry zero bit zero, selecting inverse video.
// - Each colour drives four on/off lines encoding its level.
// - Monochrome bypasses palette and drives its own output.
// - One, two or four planes word-interleaved, starting at even address.
// - Frame start copies high, middle, low base into address counter.
// - Address counter advances for each display word read.
// - Memory side delivers 16-bit words; shifter serialises them.
// - Monochrome: each word bit is one pixel, on or off.
// - Four planes: same bit of four words forms index, bit zero first.
// - Scroll 0-15 picks first shown pixel; each step shifts left.
// - Line end adds extra line width words to fetch address.
// - Generate blanking, display enable, vertical and horizontal sync.
// - Software register selects 50, 60 or 71 Hz timing.
// - Fixed 250 ns slots alternate video and processor, video first.
module bvs_shifter (
    // Clock, reset, enable
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    // AHB-Lite register slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Display word fetch
    output logic MEM_REQ_O,
    output logic [23:0] MEM_ADDR_O,
    output logic VIDEO_SLOT_O,
    input wire logic MEM_VALID_I,
    input wire logic [15:0] MEM_DATA_I,
    output logic MEM_READY_O,
    // Video outputs
    output logic [3:0] RED_O,
    output logic [3:0] GREEN_O,
    output logic [3:0] BLUE_O,
    output logic MONO_O,
    output logic BLANK_O,
    output logic DISPLAY_ENABLE_OUT_O,
    output logic HSYNC_N_O,
    output logic VSYNC_N_O
);
    import bvs_pkg::*;

    typedef struct packed {
        bvs_bus_e bus_st;
        logic ph_we;
        logic [7:0] ph_addr;
        logic [31:0] hrdata;
        logic [7:0] base_hi;
        logic [7:0] base_mid;
        logic [7:0] base_lo;
        logic [1:0] mode_sh;
        logic [1:0] rate;
        logic [3:0] hscroll;
        logic [7:0] line_width;
        logic [15:0][11:0] pal_sh;
        logic [15:0][11:0] pal;
        logic [1:0] mode;
        logic [3:0] scroll;
        logic [2:0] slot_cnt;
        logic vid_slot;
        logic [10:0] hcnt;
        logic [8:0] vcnt;
        logic [23:0] vaddr;
        logic [7:0] words_left;
        logic [3:0][15:0] gath;
        logic [2:0] gath_cnt;
        logic [3:0][15:0] plane;
        logic sh_valid;
        logic [3:0] idx;
        logic first_grp;
        logic [1:0] pdiv;
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
        logic mono;
        logic de;
        logic blank;
        logic hs_n;
        logic vs_n;
    } bvs_shifter_s;

    bvs_shifter_s r;
    bvs_shifter_s next_r;

    bvs_stream_if #(.W(16)) fill_if ();
    bvs_stream_if #(.W(16)) drain_if ();

    logic take;
    logic accept;
    logic v_act;
    logic de_area;
    logic tick;
    logic line_end;
    logic load;
    logic [3:0] pix;
    logic [10:0] de_end;

    // Per-mode and per-rate lookups
    function automatic logic [2:0] wpg(input logic [1:0] m);
        case (m)
            MODE_MED: wpg = WPG_MED;
            MODE_MONO: wpg = WPG_MONO;
            default: wpg = WPG_LOW;
        endcase
    endfunction

    function automatic logic [1:0] div_max(input logic [1:0] m);
        case (m)
            MODE_MED: div_max = DIV_MED;
            MODE_MONO: div_max = DIV_MONO;
            default: div_max = DIV_LOW;
        endcase
    endfunction

    function automatic logic [10:0] h_total(input logic [1:0] rt);
        case (rt)
            RATE_60: h_total = H_TOTAL_60;
            RATE_71: h_total = H_TOTAL_71;
            default: h_total = H_TOTAL_50;
        endcase
    endfunction

    function automatic logic [8:0] v_total(input logic [1:0] rt);
        case (rt)
            RATE_60: v_total = V_TOTAL_60;
            RATE_71: v_total = V_TOTAL_71;
            default: v_total = V_TOTAL_50;
        endcase
    endfunction

    function automatic logic [8:0] v_start(input logic [1:0] rt);
        case (rt)
            RATE_60: v_start = V_START_60;
            RATE_71: v_start = V_START_71;
            default: v_start = V_START_50;
        endcase
    endfunction

    // Words fetched per line, one extra group when scrolled
    function automatic logic [7:0] line_words(input logic [1:0] m,
                                              input logic [3:0] sc);
        logic [7:0] grp;
        grp = (m == MODE_LOW) ? 8'(GROUPS_LOW) : 8'(GROUPS_WIDE);
        grp = grp + 8'(sc != 4'h0);
        line_words = 8'(grp * 8'(wpg(m)));
    endfunction

    // Fetched words enter the buffer; back-pressure reaches memory side
    assign fill_if.valid = MEM_VALID_I;
    assign fill_if.data = MEM_DATA_I;
    assign MEM_READY_O = fill_if.ready;
    assign accept = MEM_VALID_I && fill_if.ready;
    assign drain_if.ready = (r.gath_cnt < wpg(r.mode));

    bvs_fifo #(.WIDTH(16), .DEPTH(4)) u_fifo (
        .clk_i(MCLK_I),
        .rst_i(SYS_RST_I),
        .ce_i(CE_I),
        .fill(fill_if.sink),
        .drain(drain_if.source)
    );

    // Bus take strobe, then window and strobe terms from the raster counters
    assign take = HSEL_I && HREADY_I && HTRANS_I[1];
    assign v_act = (r.vcnt >= v_start(r.rate)) &&
        (r.vcnt < v_start(r.rate) +
        ((r.mode == MODE_MONO) ? V_LINES_MONO : V_LINES_COLOUR));
    assign de_end = H_DE_START +
        ((r.mode == MODE_MONO) ? ACT_CYC_MONO : ACT_CYC_COLOUR);
    assign de_area = v_act && (r.hcnt >= H_DE_START) && (r.hcnt < de_end);
    assign tick = de_area && (r.pdiv == 2'h0);
    assign line_end = (r.hcnt == h_total(r.rate) - 11'h001);
    assign load = (r.gath_cnt == wpg(r.mode)) &&
        (!r.sh_valid || (tick && r.idx == 4'hF));

    // Palette index from the current bit of each plane
    always_comb begin
        pix = {r.plane[3][r.idx], r.plane[2][r.idx],
               r.plane[1][r.idx], r.plane[0][r.idx]};
        if (r.mode == MODE_MED) begin
            pix[3:2] = 2'h0;
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        next_r = r;

        // Bus: writes land in the data phase, reads wait one cycle
        if (r.ph_we) begin
            case (r.ph_addr)
                ADR_BASE_HI: next_r.base_hi = HWDATA_I[7:0];
                ADR_BASE_MID: next_r.base_mid = HWDATA_I[7:0];
                ADR_BASE_LO: next_r.base_lo = {HWDATA_I[7:1], 1'b0};
                ADR_MODE: next_r.mode_sh = HWDATA_I[1:0];
                ADR_RATE: next_r.rate = HWDATA_I[1:0];
                ADR_HSCROLL: next_r.hscroll = HWDATA_I[3:0];
                ADR_LINE_WIDTH: next_r.line_width = HWDATA_I[7:0];
                default: begin
                    if (r.ph_addr[7:6] == PAL_WINDOW) begin
                        next_r.pal_sh[r.ph_addr[5:2]] = HWDATA_I[11:0];
                    end
                end
            endcase
        end
        next_r.ph_we = 1'b0;
        case (r.bus_st)
            BVS_BUS_RDWAIT: begin
                next_r.bus_st = BVS_BUS_IDLE;
                case (r.ph_addr)
                    ADR_BASE_HI: next_r.hrdata = 32'(r.base_hi);
                    ADR_BASE_MID: next_r.hrdata = 32'(r.base_mid);
                    ADR_BASE_LO: next_r.hrdata = 32'(r.base_lo);
                    ADR_COUNTER: next_r.hrdata = 32'(r.vaddr);
                    ADR_MODE: next_r.hrdata = 32'(r.mode_sh);
                    ADR_RATE: next_r.hrdata = 32'(r.rate);
                    ADR_HSCROLL: next_r.hrdata = 32'(r.hscroll);
                    ADR_LINE_WIDTH: next_r.hrdata = 32'(r.line_width);
                    ADR_STATUS: begin
                        next_r.hrdata = 32'h0000_0000;
                        next_r.hrdata[STAT_VLINE_LSB +: 9] = r.vcnt;
                        next_r.hrdata[2:0] = {r.vid_slot, !v_act, r.de};
                    end
                    default: begin
                        next_r.hrdata = 32'h0000_0000;
                        if (r.ph_addr[7:6] == PAL_WINDOW) begin
                            next_r.hrdata = 32'(r.pal_sh[r.ph_addr[5:2]]);
                        end
                    end
                endcase
            end
            default: begin
                next_r.bus_st = BVS_BUS_IDLE;
                if (take) begin
                    next_r.ph_addr = HADDR_I[7:0];
                    next_r.ph_we = HWRITE_I;
                    if (!HWRITE_I) begin
                        next_r.bus_st = BVS_BUS_RDWAIT;
                    end
                end
            end
        endcase

        // Memory slots alternate, video slot first
        if (r.slot_cnt == SLOT_CYC - 3'h1) begin
            next_r.slot_cnt = 3'h0;
            next_r.vid_slot = !r.vid_slot;
        end else begin
            next_r.slot_cnt = r.slot_cnt + 3'h1;
        end

        // Raster counters
        if (line_end) begin
            next_r.hcnt = 11'h000;
            if (r.vcnt == v_total(r.rate) - 9'h001) begin
                next_r.vcnt = 9'h000;
            end else begin
                next_r.vcnt = r.vcnt + 9'h001;
            end
        end else begin
            next_r.hcnt = r.hcnt + 11'h001;
        end

        // Address counter: one word per accepted fetch, skip at line end
        if (accept) begin
            next_r.vaddr = r.vaddr + 24'h00_0002;
            if (r.words_left != 8'h00) begin
                next_r.words_left = r.words_left - 8'h01;
            end
        end
        if (line_end && v_act) begin
            next_r.vaddr = next_r.vaddr + {15'h0, r.line_width, 1'b0};
        end

        // Line start: arm fetch count, latch scroll, drop stale pixels
        if (r.hcnt == 11'h000 && v_act) begin
            next_r.words_left = line_words(r.mode, r.hscroll);
            next_r.scroll = r.hscroll;
            next_r.first_grp = 1'b1;
            next_r.sh_valid = 1'b0;
            next_r.gath_cnt = 3'h0;
        end

        // Frame start reloads counter from base and takes new mode
        if (r.hcnt == 11'h000 && r.vcnt == 9'h000) begin
            next_r.vaddr = {r.base_hi, r.base_mid, r.base_lo};
            next_r.mode = r.mode_sh;
            next_r.words_left = 8'h00;
        end

        // Gather one group of plane words from the buffer
        if (drain_if.valid && drain_if.ready) begin
            next_r.gath[r.gath_cnt[1:0]] = drain_if.data;
            next_r.gath_cnt = r.gath_cnt + 3'h1;
        end

        // Pixel divider restarts at each line's display window
        if (!de_area) begin
            next_r.pdiv = 2'h0;
        end else if (r.pdiv == div_max(r.mode)) begin
            next_r.pdiv = 2'h0;
        end else begin
            next_r.pdiv = r.pdiv + 2'h1;
        end

        // Serialise bits, lowest first
        if (tick && r.sh_valid) begin
            next_r.idx = r.idx + 4'h1;
            if (r.idx == 4'hF) begin
                next_r.sh_valid = 1'b0;
            end
            if (r.mode == MODE_MONO) begin
                next_r.mono = r.plane[0][r.idx] ^
                    r.pal[0][PAL_INVERT_BIT];
                next_r.red = 4'h0;
                next_r.green = 4'h0;
                next_r.blue = 4'h0;
            end else begin
                next_r.mono = 1'b0;
                next_r.red = r.pal[pix][PAL_RED_LSB +: 4];
                next_r.green = r.pal[pix][PAL_GREEN_LSB +: 4];
                next_r.blue = r.pal[pix][PAL_BLUE_LSB +: 4];
            end
        end else if (!de_area) begin
            next_r.mono = 1'b0;
            next_r.red = 4'h0;
            next_r.green = 4'h0;
            next_r.blue = 4'h0;
        end

        // Move a full group into the shifter, first one scrolled
        if (load && !(r.hcnt == 11'h000 && v_act)) begin
            next_r.plane = r.gath;
            next_r.gath_cnt = 3'h0;
            next_r.sh_valid = 1'b1;
            next_r.first_grp = 1'b0;
            next_r.idx = r.first_grp ? r.scroll : 4'h0;
        end

        // Palette copy only between pixels
        if (tick || !de_area) begin
            next_r.pal = r.pal_sh;
        end

        // Sync, blank and display enable
        next_r.de = de_area;
        next_r.blank = !de_area;
        next_r.hs_n = !(r.hcnt < H_SYNC_LEN);
        next_r.vs_n = !(r.vcnt < V_SYNC_LINES);
    end

    // State register
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            r <= '0;
            r.bus_st <= BVS_BUS_IDLE;
            r.vid_slot <= 1'b1;
            r.blank <= 1'b1;
            r.hs_n <= 1'b1;
            r.vs_n <= 1'b1;
        end else if (CE_I) begin
            r <= next_r;
        end
    end

    // Output drive
    assign HRDATA_O = r.hrdata;
    assign HREADYOUT_O = (r.bus_st != BVS_BUS_RDWAIT);
    assign HRESP_O = 1'b0;
    assign MEM_REQ_O = r.vid_slot && (r.words_left != 8'h00);
    assign MEM_ADDR_O = r.vaddr;
    assign VIDEO_SLOT_O = r.vid_slot;
    assign RED_O = r.red;
    assign GREEN_O = r.green;
    assign BLUE_O = r.blue;
    assign MONO_O = r.mono;
    assign BLANK_O = r.blank;
    assign DISPLAY_ENABLE_OUT_O = r.de;
    assign HSYNC_N_O = r.hs_n;
    assign VSYNC_N_O = r.vs_n;

endmodule

// ### bvs_pkg.sv
package bvs_pkg;

    // Clock and memory slot timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLOT_NS = 250;
    localparam int SLOT_CYC_INT = (SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SLOT_CYC = 3'(SLOT_CYC_INT);

    // Register byte offsets within the slave window
    localparam logic [7:0] ADR_BASE_HI = 8'h00;
    localparam logic [7:0] ADR_BASE_MID = 8'h04;
    localparam logic [7:0] ADR_BASE_LO = 8'h08;
    localparam logic [7:0] ADR_COUNTER = 8'h0C;
    localparam logic [7:0] ADR_MODE = 8'h10;
    localparam logic [7:0] ADR_RATE = 8'h14;
    localparam logic [7:0] ADR_HSCROLL = 8'h18;
    localparam logic [7:0] ADR_LINE_WIDTH = 8'h1C;
    localparam logic [7:0] ADR_STATUS = 8'h20;
    localparam logic [1:0] PAL_WINDOW = 2'h1;

    // Palette entry layout: red 11:8, green 7:4, blue 3:0
    localparam int PAL_ENTRIES = 16;
    localparam int PAL_RED_LSB = 8;
    localparam int PAL_GREEN_LSB = 4;
    localparam int PAL_BLUE_LSB = 0;
    localparam int PAL_INVERT_BIT = 0;
    localparam int STAT_VLINE_LSB = 16;

    // Resolution and refresh codes
    localparam logic [1:0] MODE_LOW = 2'h0;
    localparam logic [1:0] MODE_MED = 2'h1;
    localparam logic [1:0] MODE_MONO = 2'h2;
    localparam logic [1:0] RATE_50 = 2'h0;
    localparam logic [1:0] RATE_60 = 2'h1;
    localparam logic [1:0] RATE_71 = 2'h2;

    // Words per group, cycles per pixel less one, groups per line
    localparam logic [2:0] WPG_LOW = 3'h4;
    localparam logic [2:0] WPG_MED = 3'h2;
    localparam logic [2:0] WPG_MONO = 3'h1;
    localparam logic [1:0] DIV_LOW = 2'h3;
    localparam logic [1:0] DIV_MED = 2'h1;
    localparam logic [1:0] DIV_MONO = 2'h0;
    localparam logic [5:0] GROUPS_LOW = 6'h14;
    localparam logic [5:0] GROUPS_WIDE = 6'h28;

    // Horizontal timing in clock cycles
    localparam logic [10:0] H_TOTAL_50 = 11'h640;
    localparam logic [10:0] H_TOTAL_60 = 11'h636;
    localparam logic [10:0] H_TOTAL_71 = 11'h2B9;
    localparam logic [10:0] H_DE_START = 11'h030;
    localparam logic [10:0] H_SYNC_LEN = 11'h018;
    localparam logic [10:0] ACT_CYC_COLOUR = 11'h500;
    localparam logic [10:0] ACT_CYC_MONO = 11'h280;

    // Vertical timing in lines
    localparam logic [8:0] V_TOTAL_50 = 9'h0FA;
    localparam logic [8:0] V_TOTAL_60 = 9'h0D2;
    localparam logic [8:0] V_TOTAL_71 = 9'h194;
    localparam logic [8:0] V_START_50 = 9'h01E;
    localparam logic [8:0] V_START_60 = 9'h006;
    localparam logic [8:0] V_START_71 = 9'h002;
    localparam logic [8:0] V_SYNC_LINES = 9'h002;
    localparam logic [8:0] V_LINES_COLOUR = 9'h0C8;
    localparam logic [8:0] V_LINES_MONO = 9'h190;

    // Register slave sequencing
    typedef enum logic [1:0] {
        BVS_BUS_IDLE = 2'b01,
        BVS_BUS_RDWAIT = 2'b10
    } bvs_bus_e;

endpackage

// ### bvs_stream_if.sv
`timescale 1ns/10ps
interface bvs_stream_if #(parameter int W = 16) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface

// ### bvs_fifo.sv
`timescale 1ns/10ps
module bvs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Stream ports
    bvs_stream_if.sink fill,
    bvs_stream_if.source drain
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] slot;
        logic [CW-1:0] cnt;
    } bvs_fifo_s;

    bvs_fifo_s r;
    bvs_fifo_s next_r;
    logic push;
    logic pop;

    // Handshakes from the registered count; head word is a register
    assign fill.ready = (r.cnt != CW'(DEPTH));
    assign drain.valid = (r.cnt != '0);
    assign drain.data = r.slot[0];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    // Shift down on pop, write behind the last live entry on push
    always_comb begin
        next_r = r;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_r.slot[i] = r.slot[i+1];
            end
        end
        if (push) begin
            next_r.slot[r.cnt - CW'(pop)] = fill.data;
        end
        next_r.cnt = r.cnt + CW'(push) - CW'(pop);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

endmodule

// ### bvs_top_note_unused.sv
`timescale 1ns/10ps

// ### bvs_shifter_assertions.sv
`timescale 1ns/10ps
module bvs_shifter_assertions (
    // Clock and reset
    input wire logic MCLK_I,
    input wire logic SYS_RST_I,
    // Register bus
    input wire logic CE_I,
    input wire logic HSEL_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic HREADYOUT_O,
    // Fetch link
    input wire logic MEM_REQ_O,
    input wire logic [23:0] MEM_ADDR_O,
    input wire logic VIDEO_SLOT_O,
    input wire logic MEM_VALID_I,
    input wire logic MEM_READY_O,
    // Video
    input wire logic [3:0] RED_O,
    input wire logic [3:0] GREEN_O,
    input wire logic [3:0] BLUE_O,
    input wire logic MONO_O,
    input wire logic BLANK_O,
    input wire logic DISPLAY_ENABLE_OUT_O,
    input wire logic HSYNC_N_O
);
    logic [10:0] hs_cnt;
    logic [10:0] de_cnt;

    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SYS_RST_I);

    // Cycles spent in sync pulse and in active area
    always_ff @(posedge MCLK_I) begin
        hs_cnt <= HSYNC_N_O ? 11'h000 : hs_cnt + 11'h001;
        de_cnt <= DISPLAY_ENABLE_OUT_O ? de_cnt + 11'h001 : 11'h000;
    end

    // Slot timing and request gating
    property p_slot_len;
        $rose(VIDEO_SLOT_O) |-> VIDEO_SLOT_O [*5] ##1 !VIDEO_SLOT_O;
    endproperty
    a_slot_len: assert property (p_slot_len) else $error("slot length");
    property p_req_slot;
        MEM_REQ_O |-> VIDEO_SLOT_O;
    endproperty
    a_req_slot: assert property (p_req_slot) else $error("req off slot");

    // Fetch address steps per taken word, holds on refusal
    property p_addr_step;
        MEM_VALID_I && MEM_READY_O |=> MEM_ADDR_O == $past(MEM_ADDR_O) + 2;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("addr step");
    property p_refuse_hold;
        MEM_VALID_I && !MEM_READY_O |=> $stable(MEM_ADDR_O);
    endproperty
    a_refuse_hold: assert property (p_refuse_hold) else $error("hold");

    // Raster outputs
    property p_hsync_len;
        $rose(HSYNC_N_O) |-> hs_cnt == 11'h018;
    endproperty
    a_hsync_len: assert property (p_hsync_len) else $error("hsync");
    property p_de_len;
        $fell(DISPLAY_ENABLE_OUT_O) |-> de_cnt == 11'h500 || de_cnt == 11'h280;
    endproperty
    a_de_len: assert property (p_de_len) else $error("de length");
    property p_blank;
        BLANK_O != DISPLAY_ENABLE_OUT_O;
    endproperty
    a_blank: assert property (p_blank) else $error("blank");
    property p_dark;
        !DISPLAY_ENABLE_OUT_O |-> {RED_O, GREEN_O, BLUE_O, MONO_O} == 13'h0000;
    endproperty
    a_dark: assert property (p_dark) else $error("colour outside");

    // Register read inserts exactly one wait
    property p_rd_wait;
        HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I && CE_I
            |=> !HREADYOUT_O ##1 HREADYOUT_O;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait");

    // Main scenarios
    c_word: cover property (MEM_VALID_I && MEM_READY_O);
    c_full: cover property (MEM_VALID_I && !MEM_READY_O);
    c_line: cover property ($fell(DISPLAY_ENABLE_OUT_O));
endmodule

bind bvs_shifter bvs_shifter_assertions chk_u (
    .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .HSEL_I(HSEL_I),
    .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I),
    .HREADYOUT_O(HREADYOUT_O), .MEM_REQ_O(MEM_REQ_O),
    .MEM_ADDR_O(MEM_ADDR_O), .VIDEO_SLOT_O(VIDEO_SLOT_O),
    .MEM_VALID_I(MEM_VALID_I), .MEM_READY_O(MEM_READY_O), .RED_O(RED_O),
    .GREEN_O(GREEN_O), .BLUE_O(BLUE_O), .MONO_O(MONO_O), .BLANK_O(BLANK_O),
    .DISPLAY_ENABLE_OUT_O(DISPLAY_ENABLE_OUT_O), .HSYNC_N_O(HSYNC_N_O)
);

// ### bvs_mem_model.sv
`timescale 1ns/10ps
module bvs_mem_model (
    // Clock, reset, pace
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    // Fetch link
    input wire logic req_i,
    input wire logic slot_i,
    input wire logic ready_i,
    output logic valid_o = 1'b0,
    output logic [15:0] data_o = 16'h0000
);
    logic [1:0] plane;
    logic done;
    logic late;
    // Bit b of plane p equals bit p of b, so pixel index equals bit
    logic [15:0] word [4] = '{16'hAAAA, 16'hCCCC, 16'hF0F0, 16'hFF00};

    // One word per video slot, held until taken, then scrambled
    always @(posedge clk_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
            plane <= 2'h0;
            done <= 1'b0;
            late <= 1'b0;
        end else if (valid_o) begin
            if (ready_i) begin
                valid_o <= 1'b0;
                data_o <= ~data_o;
                plane <= plane + 2'h1;
            end
        end else if (!slot_i) begin
            done <= 1'b0;
            late <= 1'b0;
        end else if (req_i && !done && (late || !slow_i)) begin
            valid_o <= 1'b1;
            data_o <= word[plane];
            done <= 1'b1;
        end else begin
            late <= req_i;
        end
    end
endmodule

// ### bitplane_video_shifter_tb_top.sv
`timescale 1ns/10ps
module bitplane_video_shifter_tb_top;
    import bvs_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hready, hresp, mreq, mslot, mvalid, mready;
    logic mono, blank, de, hs_n, vs_n;
    logic [15:0] mdata;
    logic [23:0] maddr;
    logic [3:0] red, green, blue;
    int miscompares = 0;
    int cmp_count = 0;

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    bvs_shifter dut_u (
        .MCLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1), .HSEL_I(1'b1),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
        .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
        .MEM_REQ_O(mreq), .MEM_ADDR_O(maddr), .VIDEO_SLOT_O(mslot),
        .MEM_VALID_I(mvalid), .MEM_DATA_I(mdata), .MEM_READY_O(mready),
        .RED_O(red), .GREEN_O(green), .BLUE_O(blue), .MONO_O(mono),
        .BLANK_O(blank), .DISPLAY_ENABLE_OUT_O(de), .HSYNC_N_O(hs_n),
        .VSYNC_N_O(vs_n)
    );

    bvs_mem_model mem_u (
        .clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(mreq),
        .slot_i(mslot), .ready_i(mready), .valid_o(mvalid), .data_o(mdata)
    );

    // Verdict and end of run
    task automatic complete_run;
        $display("Compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Wait for hready (sel 0), display enable (1) or hsync (2) to reach v
    task automatic hold(input int sel, input logic v, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(posedge clk);
            if ((sel == 0 ? hready : sel == 1 ? de : hs_n) === v) return;
        end
        miscompares++;
        complete_run;
    endtask

    // Single word transfer, read data left in rd
    task automatic ahb(input logic wr, input logic [7:0] a, logic [31:0] wd);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        hold(0, 1'b1, 20);
        htrans <= 2'h0;
        hwdata <= wd;
        hold(0, 1'b1, 20);
        rd = hrdata;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, e);
    endtask

    // Palette colour chosen for index i
    function automatic logic [11:0] pal(input int i);
        return {4'(i), 4'(15 - i), 4'(i) ^ 4'h5};
    endfunction

    // First sixteen pixels of the next line, sampled mid-pixel
    task automatic pixels(input int sc);
        hold(1, 1'b1, 60000);
        @(posedge clk);
        for (int k = 0; k < 16; k++) begin
            rd = {20'h0_0000, red, green, blue};
            chk("pixel", rd, {20'h0_0000, pal((k + sc) % 16)});
            repeat (4) @(posedge clk);
        end
    endtask

    // Fetch address at next line start, after the extra width is added
    task automatic line_end(input logic [31:0] e);
        hold(1, 1'b0, 2000);
        hold(2, 1'b0, 2000);
        chk("fetch address", {8'h00, maddr}, e);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rd = {maddr, hready, hresp, mreq, mslot, blank, de, hs_n, vs_n};
        chk("reset outputs", rd, 32'h0000_009B);
        rst <= 1'b0;
        @(posedge clk);
        // Refresh select codes, palette width, base alignment, holes
        rdchk("rate reset", ADR_RATE, 32'h0000_0000);
        for (int i = 3; i >= 0; i--) begin
            ahb(1'b1, ADR_RATE, {30'h0000_0000, 2'(i)});
            rdchk("rate", ADR_RATE, {30'h0000_0000, 2'(i)});
        end
        for (int i = 0; i < 16; i++) begin
            ahb(1'b1, 8'h40 + 8'(4 * i), {20'hF_EDCB, pal(i)});
        end
        rdchk("palette", 8'h7C, {20'h0_0000, pal(15)});
        ahb(1'b1, ADR_BASE_LO, 32'h0000_0035);
        rdchk("base low", ADR_BASE_LO, 32'h0000_0034);
        ahb(1'b1, ADR_MODE, 32'h0000_0002);
        rdchk("mode", ADR_MODE, 32'h0000_0002);
        ahb(1'b1, ADR_MODE, 32'h0000_0000);
        rdchk("unmapped", 8'h30, 32'h0000_0000);
        // Line one unscrolled, then scroll and extra width, slow memory
        pixels(0);
        ahb(1'b1, ADR_HSCROLL, 32'h0000_0003);
        ahb(1'b1, ADR_LINE_WIDTH, 32'h0000_0005);
        slow <= 1'b1;
        line_end(32'h0000_00AA);
        pixels(3);
        line_end(32'h0000_015C);
        // Address counter is read-only; probe once next line's fetch ends
        hold(1, 1'b1, 2000);
        hold(1, 1'b0, 2000);
        rdchk("counter", ADR_COUNTER, 32'h0000_0204);
        ahb(1'b1, ADR_COUNTER, 32'h0000_0000);
        rdchk("counter kept", ADR_COUNTER, 32'h0000_0204);
        complete_run;
    end
endmodule
